// [hw/isv_judge.v]
`timescale 1ns/100ps
`default_nettype none
// Per-input validity decision from the alarm flags
module isv_judge #(
  parameter N = 14
) (
  // Alarm flags per input
  input  wire [N-1:0] i_soft_alarm,
  input  wire [N-1:0] i_hard_alarm,
  input  wire [N-1:0] i_activity_alarm,
  input  wire [N-1:0] i_lock_alarm,
  // Decision
  output wire [N-1:0] o_valid
);

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_in
      wire serious_w;
      // Any alarm other than the soft one disqualifies
      assign serious_w = i_hard_alarm[g] | i_activity_alarm[g] | i_lock_alarm[g];
      assign o_valid[g] = ~(serious_w | i_soft_alarm[g]) | (i_soft_alarm[g] & ~serious_w);
    end
  endgenerate

endmodule
`default_nettype wire

// [hw/isv_regs.vh]
`ifndef ISV_REGS_VH
`define ISV_REGS_VH

// Register offsets on the plain register port
`define ISV_ADDR_VALID_LOW   8'h00
`define ISV_ADDR_VALID_HIGH  8'h01
`define ISV_ADDR_IRQ_STATUS  8'h02
`define ISV_ADDR_IRQ_MASK    8'h03
`define ISV_ADDR_IRQ_STAT_HI 8'h04
`define ISV_ADDR_IRQ_MASK_HI 8'h05

// Field positions
`define ISV_HIGH_USED_MSB    5
`define ISV_NUM_INPUTS       14
`define ISV_LOW_BITS         8

// Reset values
`define ISV_VALID_RESET      14'h0000
`define ISV_IRQ_RESET        14'h0000
`define ISV_BYTE_ZERO        8'h00
`define ISV_SYNC_QUIET       14'h0000
`define ISV_SYNC_ALARM       14'h3FFF
`define ISV_MASK_HI_RESET    6'h00

`endif

// [hw/isv_top.v]
`timescale 1ns/100ps
`default_nettype none
`include "isv_regs.vh"
module isv_top #(
  parameter N = `ISV_NUM_INPUTS
) (
  // Clock and reset
  input  wire         i_sys_clk,
  input  wire         i_rst,
  // Alarm flags from the input monitors (asynchronous)
  input  wire [N-1:0] i_soft_alarm,
  input  wire [N-1:0] i_hard_alarm,
  input  wire [N-1:0] i_activity_alarm,
  input  wire [N-1:0] i_lock_alarm,
  // Register port
  input  wire [7:0]   i_addr,
  input  wire [7:0]   i_wdata,
  input  wire         i_wr,
  input  wire         i_rd,
  output reg  [7:0]   o_rdata,
  // Interrupt and status
  output wire         o_irq,
  output wire [N-1:0] o_valid
);

  // Byte split of the input vector
  localparam LO_W  = `ISV_LOW_BITS;
  localparam HI_W  = N - LO_W;
  localparam PAD_W = LO_W - HI_W;

  // Alarm synchronisers, first and second stage
  reg  [N-1:0]    soft_s1_q;
  reg  [N-1:0]    hard_s1_q;
  reg  [N-1:0]    act_s1_q;
  reg  [N-1:0]    lock_s1_q;
  reg  [N-1:0]    soft_s2_q;
  reg  [N-1:0]    hard_s2_q;
  reg  [N-1:0]    act_s2_q;
  reg  [N-1:0]    lock_s2_q;
  // Validity and interrupt state
  reg  [N-1:0]    valid_q;
  wire [N-1:0]    valid_d;
  wire [N-1:0]    change_w;
  reg  [N-1:0]    irq_stat_q;
  reg  [LO_W-1:0] mask_lo_q;
  reg  [HI_W-1:0] mask_hi_q;
  wire [N-1:0]    irq_mask_w;
  wire [N-1:0]    clr_lo_w;
  wire [N-1:0]    clr_hi_w;
  wire [N-1:0]    clr_w;
  // Register port decode
  wire            wr_stat_lo_w;
  wire            wr_stat_hi_w;
  wire            wr_mask_lo_w;
  wire            wr_mask_hi_w;
  // Read path
  wire [LO_W-1:0] valid_lo_w;
  wire [LO_W-1:0] valid_hi_w;
  wire [LO_W-1:0] stat_hi_w;
  wire [LO_W-1:0] mask_hi_w;
  reg  [7:0]      rdata_d;

  // no write path to validity
  // Only the interrupt bytes decode writes; validity offsets fall through
  assign wr_stat_lo_w = i_wr & (i_addr == `ISV_ADDR_IRQ_STATUS);
  assign wr_stat_hi_w = i_wr & (i_addr == `ISV_ADDR_IRQ_STAT_HI);
  assign wr_mask_lo_w = i_wr & (i_addr == `ISV_ADDR_IRQ_MASK);
  assign wr_mask_hi_w = i_wr & (i_addr == `ISV_ADDR_IRQ_MASK_HI);

  // Soft alarm sync; first stage feeds only the second
  // Starts quiet, since a soft alarm never invalidates an input
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      soft_s1_q <= `ISV_SYNC_QUIET;
      soft_s2_q <= `ISV_SYNC_QUIET;
    end else begin
      soft_s1_q <= i_soft_alarm;
      soft_s2_q <= soft_s1_q;
    end
  end

  // alarm assumed until evaluated
  // Hard alarm sync starts raised so no input reads valid on stale stages
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      hard_s1_q <= `ISV_SYNC_ALARM;
      hard_s2_q <= `ISV_SYNC_ALARM;
    end else begin
      hard_s1_q <= i_hard_alarm;
      hard_s2_q <= hard_s1_q;
    end
  end

  // Activity alarm sync, same pessimistic start
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      act_s1_q <= `ISV_SYNC_ALARM;
      act_s2_q <= `ISV_SYNC_ALARM;
    end else begin
      act_s1_q <= i_activity_alarm;
      act_s2_q <= act_s1_q;
    end
  end

  // Lock alarm sync, same pessimistic start
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_s1_q <= `ISV_SYNC_ALARM;
      lock_s2_q <= `ISV_SYNC_ALARM;
    end else begin
      lock_s1_q <= i_lock_alarm;
      lock_s2_q <= lock_s1_q;
    end
  end

  // Validity decision per input
  isv_judge #(
    .N (N)
  ) u_judge (
    .i_soft_alarm     (soft_s2_q),
    .i_hard_alarm     (hard_s2_q),
    .i_activity_alarm (act_s2_q),
    .i_lock_alarm     (lock_s2_q),
    .o_valid          (valid_d)
  );

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      valid_q <= `ISV_VALID_RESET;
    end else begin
      valid_q <= valid_d;
    end
  end

  assign o_valid = valid_q;

  // Any change of a validity bit, either way, is an interrupt event
  assign change_w = valid_q ^ valid_d;

  // Write-one-to-clear masks for the two status bytes
  assign clr_lo_w = wr_stat_lo_w ? {{HI_W{1'h0}}, i_wdata} : {N{1'h0}};
  assign clr_hi_w = wr_stat_hi_w ? {i_wdata[HI_W-1:0], {LO_W{1'h0}}} : {N{1'h0}};
  assign clr_w    = clr_lo_w | clr_hi_w;

  // Sticky change events; a new event beats a same-cycle clear
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_q <= `ISV_IRQ_RESET;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_w) | change_w;
    end
  end

  // Interrupt mask, low byte
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_lo_q <= `ISV_BYTE_ZERO;
    end else if (wr_mask_lo_w) begin
      mask_lo_q <= i_wdata;
    end
  end

  // Interrupt mask, high byte; bits above the last input are not stored
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_hi_q <= `ISV_MASK_HI_RESET;
    end else if (wr_mask_hi_w) begin
      mask_hi_q <= i_wdata[HI_W-1:0];
    end
  end

  assign irq_mask_w = {mask_hi_q, mask_lo_q};

  // Level interrupt; stays up until the status bit is cleared or masked
  assign o_irq = |(irq_stat_q & irq_mask_w);

  // Byte views for the read mux
  assign valid_lo_w = valid_q[LO_W-1:0];
  assign valid_hi_w = {{PAD_W{1'h0}}, valid_q[N-1:LO_W]};
  assign stat_hi_w  = {{PAD_W{1'h0}}, irq_stat_q[N-1:LO_W]};
  assign mask_hi_w  = {{PAD_W{1'h0}}, mask_hi_q};

  // Read mux; writes to the validity bytes have no effect
  always @* begin
    rdata_d = `ISV_BYTE_ZERO;
    case (i_addr)
      `ISV_ADDR_VALID_LOW:   rdata_d = valid_lo_w;
      `ISV_ADDR_VALID_HIGH:  rdata_d = valid_hi_w;
      `ISV_ADDR_IRQ_STATUS:  rdata_d = irq_stat_q[LO_W-1:0];
      `ISV_ADDR_IRQ_MASK:    rdata_d = mask_lo_q;
      `ISV_ADDR_IRQ_STAT_HI: rdata_d = stat_hi_w;
      `ISV_ADDR_IRQ_MASK_HI: rdata_d = mask_hi_w;
      default:               rdata_d = `ISV_BYTE_ZERO;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= `ISV_BYTE_ZERO;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= `ISV_BYTE_ZERO;
    end
  end

endmodule
`default_nettype wire

// [test/isv_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module isv_checker #(
  parameter N = 14
) (
  // Clock and reset
  input wire logic         i_sys_clk,
  input wire logic         i_rst,
  // Register port
  input wire logic         i_rd,
  input wire logic [7:0]   i_addr,
  input wire logic [7:0]   o_rdata,
  // Alarms and validity
  input wire logic [N-1:0] i_hard_alarm,
  input wire logic [N-1:0] i_activity_alarm,
  input wire logic [N-1:0] i_lock_alarm,
  input wire logic [N-1:0] o_valid
);
  // Soft alarm never counts against an input
  wire logic [N-1:0] bad = i_hard_alarm | i_activity_alarm | i_lock_alarm;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Three clean edges needed, sync stages restart at reset
  a_valid_follows: assert property (!$past(i_rst, 3) && !$past(i_rst, 2) && !$past(i_rst)
    |-> o_valid == ~$past(bad, 3)) else $error("validity wrong");
  a_low_byte: assert property (i_rd && i_addr == 8'h00 |=> o_rdata == $past(o_valid[7:0]))
    else $error("low byte wrong");
  a_high_byte: assert property (i_rd && i_addr == 8'h01 |=> o_rdata == {2'h0, $past(o_valid[N-1:8])})
    else $error("high byte wrong");
  // Nothing valid until the sync stages hold real samples
  a_reset_zero: assert property ($fell(i_rst) |-> o_valid == {N{1'h0}} ##1 o_valid == {N{1'h0}}
    ##1 o_valid == {N{1'h0}}) else $error("validity not held at zero after reset");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data lingers");
endmodule
bind isv_top isv_checker #(.N(N)) i_chk (
  .i_sys_clk        (i_sys_clk),
  .i_rst            (i_rst),
  .i_rd             (i_rd),
  .i_addr           (i_addr),
  .o_rdata          (o_rdata),
  .i_hard_alarm     (i_hard_alarm),
  .i_activity_alarm (i_activity_alarm),
  .i_lock_alarm     (i_lock_alarm),
  .o_valid          (o_valid)
);
`default_nettype wire

// [test/test_input_source_validity_status.sv]
`timescale 1ns/100ps
`default_nettype none
module test_input_source_validity_status;
  logic        clk = 0, rst = 1, wr = 0, rd = 0;
  logic [13:0] sa = 0, ha = 14'h3FFF, aa = 0, la = 0, ev;
  logic [7:0]  ad = 0, wd = 0;
  wire  [7:0]  rdata;
  wire         irq;
  int          fail_count = 0, samples_checked = 0, cyc = 0;
  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) if (++cyc > 1000) begin
    fail_count++;
    wrap_up;
  end
  isv_top i_dut (.i_sys_clk(clk), .i_rst(rst), .i_soft_alarm(sa), .i_hard_alarm(ha), .i_activity_alarm(aa),
    .i_lock_alarm(la), .i_addr(ad), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .o_valid());
  task automatic chk(string n, logic [7:0] e, s);
    samples_checked++;
    if (s !== e) begin
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
      fail_count++;
    end
  endtask
  // Expected validity: soft alarms never count against an input
  function automatic logic [13:0] exp_valid(logic [13:0] h, a, l);
    return ~(h | a | l);
  endfunction
  task automatic chk_irq(logic e);
    samples_checked++;
    if (irq !== e) begin
      $display("CHECK FAILED irq exp %h got %h", e, irq);
      fail_count++;
    end
  endtask
  task automatic wt(logic [7:0] a, v);
    ad <= a; wd <= v; wr <= 1;
    @(posedge clk) wr <= 0;
  endtask
  // Data sampled before the edge's own updates land
  task automatic rc(logic [7:0] a, e);
    ad <= a; rd <= 1;
    @(posedge clk) rd <= 0;
    @(posedge clk) chk("rdata", e, rdata);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hard alarms held so validity stays zero during the reset reads
  initial begin
    void'($urandom(23144));
    repeat (3) @(posedge clk);
    rst <= 0;
    rc(8'h00, 8'h00);
    rc(8'h01, 8'h00);
    sa <= 14'h3FFF; ha <= 14'h0000;
    repeat (4) @(posedge clk);
    rc(8'h00, 8'hFF);
    rc(8'h01, 8'h3F);
    @(posedge clk) chk_irq(1'h0);
    wt(8'h03, 8'hFF);
    @(posedge clk) chk_irq(1'h1);
    wt(8'h02, 8'hFF);
    @(posedge clk) chk_irq(1'h0);
    rc(8'h02, 8'h00);
    rc(8'h04, 8'h3F);
    rc(8'h05, 8'h00);
    // High byte of mask and status, untouched until here
    wt(8'h05, 8'hFF);
    @(posedge clk) chk_irq(1'h1);
    wt(8'h04, 8'hFF);
    @(posedge clk) chk_irq(1'h0);
    rc(8'h03, 8'hFF);
    rc(8'h05, 8'h3F);
    rc(8'h40, 8'h00);
    // Random alarm mixes, writes to the read-only bytes between
    for (int k = 0; k < 40; k++) begin
      {sa, ha, aa, la} <= 56'({$urandom, $urandom} & {$urandom, $urandom});
      repeat (4) @(posedge clk);
      ev = exp_valid(ha, aa, la);
      wt({7'h00, k[0]}, 8'($urandom));
      rc(8'h00, ev[7:0]);
      rc(8'h01, {2'h0, ev[13:8]});
    end
    rst <= 1;
    @(posedge clk) rst <= 0;
    rc(8'h00, 8'h00);
    rc(8'h01, 8'h00);
    rc(8'h05, 8'h00);
    chk_irq(1'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
